/* File: beat_order.sv */
// Column order generator for one beat of a burst.
// Assumes beat index and start column are stable in the cycle used.
module beat_order (
  // Burst descriptor
  input  wire logic       interleave_in,
  input  wire logic       is_write_in,
  input  wire logic       chop_in,
  input  wire logic [2:0] start_in,
  input  wire logic [2:0] beat_in,
  // Result
  output logic [2:0]      column_out,
  output logic            drive_out
);
  logic [2:0] start_eff;

  always_comb begin
    // Writes ignore low column bits; chopped writes keep bit 2
    start_eff = is_write_in ? {chop_in & start_in[2], 2'b00} : start_in;
    if (interleave_in) begin
      column_out = start_eff ^ beat_in;
    end else begin
      column_out = {start_eff[2] ^ beat_in[2], start_eff[1:0] + beat_in[1:0]};
    end
    drive_out = !(chop_in && beat_in[2]);
  end
endmodule // beat_order

/* File: ctl_model.sv */
// Controller model: mode sets, column commands and power strobes.
// Assumes a free-running clock; every change lands on a falling edge.
module ctl_model (
  // Clock and status
  input  wire logic   clk_in,
  input  wire logic   locked_in,
  // Commands
  output logic        mode_set_out,
  output logic        read_out,
  output logic        write_out,
  output logic [3:0]  pwr_out,
  // Address
  output logic [2:0]  bank_out,
  output logic [16:0] addr_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {mode_set_out, read_out, write_out} = 3'h0;
    pwr_out = 4'h0;
    bank_out = 3'h7;
    addr_out = 17'h1_ffff;
  end

  ////////////////////////////////////////////////////////////////////////
  // Kind 0 mode set, 1 read, 2 write; a released bus shows the inverse
  task automatic cmd(input int kind, input logic [2:0] bank, input logic [16:0] addr);
    @(negedge clk_in);
    bank_out <= bank;
    addr_out <= addr;
    mode_set_out <= (kind == 0);
    read_out <= (kind == 1);
    write_out <= (kind == 2);
    @(negedge clk_in);
    {mode_set_out, read_out, write_out} <= 3'h0;
    bank_out <= ~bank;
    addr_out <= ~addr;
  endtask

  // Callers issue this only with no burst in flight
  task automatic mset(input logic [2:0] bank, input logic [16:0] v);
    cmd(0, bank, v & ((bank == 3'h0) ? 17'h1_1f7f : 17'h0_daff));
  endtask

  // Bit 0/1 self-refresh entry/exit, 2/3 power-down entry/exit
  task automatic pwr(input int idx);
    @(negedge clk_in);
    pwr_out[idx] <= 1'b1;
    @(negedge clk_in);
    pwr_out <= 4'h0;
  endtask

  task automatic lock_wait(input int limit);
    int k;
    k = 0;
    while (!locked_in && k < limit) begin
      @(negedge clk_in);
      k++;
    end
  endtask
endmodule // ctl_model

/* File: mode_decode_pkg.sv */
// Constants for the mode-register decode block of a synchronous DRAM.
// Assumes the command decoder outside delivers one-cycle command strobes.
package mode_decode_pkg;

  // Register widths
  localparam int MODE0_W = 13;
  localparam int MODE1_W = 17;

  // Bank address selecting each mode register
  localparam logic [2:0] BANK_MODE0 = 3'h0;
  localparam logic [2:0] BANK_MODE1 = 3'h1;

  // Reset values
  localparam logic [MODE0_W-1:0] MODE0_RESET = 13'h0000;
  localparam logic [MODE1_W-1:0] MODE1_RESET = 17'h0_0000;

  // Burst length codes
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_CHOP4  = 2'h2;

  // First mode register field positions
  localparam int M0_BL_LO   = 0;
  localparam int M0_BTYPE   = 3;
  localparam int M0_CL_LO   = 4;
  localparam int M0_DLLRST  = 8;
  localparam int M0_WR_LO   = 9;
  localparam int M0_PPD     = 12;

  // Second mode register field positions
  localparam int M1_DLL_DIS = 0;
  localparam int M1_DS_LO   = 1;
  localparam int M1_DS_HI   = 5;
  localparam int M1_WLVL    = 7;
  localparam int M1_QOFF    = 12;

  // DLL-off latency and default read latency and write recovery
  localparam logic [3:0] LAT_DLL_OFF = 4'h6;
  localparam logic [3:0] CL_DEFAULT  = 4'h5;
  localparam logic [3:0] WR_DEFAULT  = 4'h5;

  // Exit delays in cycles for precharge power-down
  localparam logic [3:0] EXIT_FAST   = 4'h3;
  localparam logic [3:0] EXIT_SLOW   = 4'hA;

  // DLL lock interval in cycles
  localparam int DLL_LOCK_CYC = 512;

  // Drive strength codes
  localparam logic [1:0] DS_RZQ7 = 2'h1;
  localparam logic [1:0] DS_RZQ6 = 2'h0;

endpackage

/* File: sdram_mode_register_decode.sv */
// Mode-register store and decode for a synchronous DRAM.
// Assumes command strobes are already decoded and synchronous to clk_in.
import mode_decode_pkg::*;

module sdram_mode_register_decode #(
  parameter int LOCK_CYC = DLL_LOCK_CYC
) (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               reset_in,
  // Command strobes
  input  wire logic               mode_set_in,
  input  wire logic               read_in,
  input  wire logic               write_in,
  input  wire logic               self_refresh_entry_in,
  input  wire logic               self_refresh_exit_in,
  input  wire logic               power_down_entry_in,
  input  wire logic               power_down_exit_in,
  // Address
  input  wire logic [2:0]         bank_in,
  input  wire logic [16:0]        addr_in,
  // Register images
  output logic [MODE0_W-1:0]      mode0_out,
  output logic [MODE1_W-1:0]      mode1_out,
  // Decoded settings
  output logic [3:0]              read_latency_out,
  output logic [3:0]              write_recovery_out,
  output logic [1:0]              drive_strength_out,
  output logic                    term_all_allowed_out,
  output logic                    term_allowed_out,
  // DLL state
  output logic                    dll_running_out,
  output logic                    dll_reset_pulse_out,
  output logic                    dll_locked_out,
  output logic [3:0]              pd_exit_delay_out,
  // Burst output
  output logic                    burst_active_out,
  output logic [2:0]              column_out,
  output logic                    dq_drive_en_out,
  output logic                    dq_first_out
);

  ////////////////////////////////////////////////////////////////////
  // Register capture

  logic [MODE0_W-1:0] mode0_r;
  logic [MODE1_W-1:0] mode1_r;
  logic               dll_reset_req_r;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode0_r         <= MODE0_RESET;
      dll_reset_req_r <= 1'b0;
    end else if (mode_set_in && bank_in == BANK_MODE0) begin
      mode0_r         <= addr_in[MODE0_W-1:0];
      mode0_r[M0_DLLRST] <= 1'b0;
      dll_reset_req_r <= addr_in[M0_DLLRST];
    end else begin
      dll_reset_req_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode1_r <= MODE1_RESET;
    end else if (mode_set_in && bank_in == BANK_MODE1) begin
      mode1_r <= addr_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode0_out <= MODE0_RESET;
      mode1_out <= MODE1_RESET;
    end else begin
      mode0_out <= mode0_r;
      mode1_out <= mode1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Field decode

  logic [3:0] cl_dec;
  logic [3:0] wr_dec;
  logic       dll_enable;

  assign dll_enable = !mode1_r[M1_DLL_DIS];

  always_comb begin
    unique case (mode0_r[M0_CL_LO +: 3])
      3'h1:    cl_dec = 4'h5;
      3'h2:    cl_dec = 4'h6;
      3'h3:    cl_dec = 4'h7;
      3'h4:    cl_dec = 4'h8;
      3'h5:    cl_dec = 4'h9;
      3'h6:    cl_dec = 4'hA;
      default: cl_dec = CL_DEFAULT;
    endcase
    unique case (mode0_r[M0_WR_LO +: 3])
      3'h1:    wr_dec = 4'h5;
      3'h2:    wr_dec = 4'h6;
      3'h3:    wr_dec = 4'h7;
      3'h4:    wr_dec = 4'h8;
      3'h5:    wr_dec = 4'hA;
      3'h6:    wr_dec = 4'hC;
      default: wr_dec = WR_DEFAULT;
    endcase
    if (!dll_enable) begin
      cl_dec = LAT_DLL_OFF;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      read_latency_out     <= CL_DEFAULT;
      write_recovery_out   <= WR_DEFAULT;
      drive_strength_out   <= DS_RZQ6;
      term_all_allowed_out <= 1'b0;
      term_allowed_out     <= 1'b0;
      pd_exit_delay_out    <= EXIT_SLOW;
    end else begin
      read_latency_out     <= cl_dec;
      write_recovery_out   <= wr_dec;
      drive_strength_out   <= {mode1_r[M1_DS_HI], mode1_r[M1_DS_LO]};
      term_all_allowed_out <= mode1_r[M1_WLVL] && mode1_r[M1_QOFF];
      term_allowed_out     <= dll_enable;
      pd_exit_delay_out    <= mode0_r[M0_PPD] ? EXIT_FAST : EXIT_SLOW;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // DLL state

  logic        in_self_refresh_r;
  logic        in_power_down_r;
  logic [9:0]  lock_cnt_r;
  logic        dll_restart;

  assign dll_restart = dll_reset_req_r || (self_refresh_exit_in && dll_enable);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      in_self_refresh_r <= 1'b0;
      in_power_down_r   <= 1'b0;
    end else begin
      if (self_refresh_entry_in) begin
        in_self_refresh_r <= 1'b1;
      end else if (self_refresh_exit_in) begin
        in_self_refresh_r <= 1'b0;
      end
      if (power_down_entry_in) begin
        in_power_down_r <= 1'b1;
      end else if (power_down_exit_in) begin
        in_power_down_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dll_running_out     <= 1'b0;
      dll_reset_pulse_out <= 1'b0;
    end else begin
      dll_running_out     <= dll_enable && !in_self_refresh_r &&
                             !(in_power_down_r && !mode0_r[M0_PPD]);
      dll_reset_pulse_out <= dll_restart;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lock_cnt_r     <= 10'h000;
      dll_locked_out <= 1'b0;
    end else if (dll_restart) begin
      lock_cnt_r     <= 10'(LOCK_CYC - 1);
      dll_locked_out <= 1'b0;
    end else if (lock_cnt_r != 10'h000) begin
      lock_cnt_r     <= lock_cnt_r - 10'h001;
      dll_locked_out <= 1'b0;
    end else begin
      dll_locked_out <= dll_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Burst sequencing

  logic [3:0] lat_cnt_r;
  logic       pend_r;
  logic       pend_write_r;
  logic       pend_chop_r;
  logic [2:0] pend_start_r;
  logic       burst_r;
  logic       burst_write_r;
  logic       burst_chop_r;
  logic [2:0] burst_start_r;
  logic [2:0] beat_r;
  logic       cmd_chop;
  logic [2:0] col_nxt;
  logic       drive_nxt;

  always_comb begin
    unique case (mode0_r[M0_BL_LO +: 2])
      BL_OTF:   cmd_chop = !addr_in[12];
      BL_CHOP4: cmd_chop = 1'b1;
      default:  cmd_chop = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pend_r       <= 1'b0;
      pend_write_r <= 1'b0;
      pend_chop_r  <= 1'b0;
      pend_start_r <= 3'h0;
      lat_cnt_r    <= 4'h0;
    end else if (read_in || write_in) begin
      pend_r       <= 1'b1;
      pend_write_r <= write_in;
      pend_chop_r  <= cmd_chop;
      pend_start_r <= addr_in[2:0];
      lat_cnt_r    <= write_in ? 4'h1 : cl_dec - 4'h1;
    end else if (pend_r) begin
      if (lat_cnt_r <= 4'h1) begin
        pend_r <= 1'b0;
      end
      lat_cnt_r <= lat_cnt_r - 4'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      burst_r       <= 1'b0;
      burst_write_r <= 1'b0;
      burst_chop_r  <= 1'b0;
      burst_start_r <= 3'h0;
      beat_r        <= 3'h0;
    end else if (pend_r && lat_cnt_r <= 4'h1) begin
      burst_r       <= 1'b1;
      burst_write_r <= pend_write_r;
      burst_chop_r  <= pend_chop_r;
      burst_start_r <= pend_start_r;
      beat_r        <= 3'h0;
    end else if (burst_r) begin
      beat_r  <= beat_r + 3'h1;
      burst_r <= beat_r != 3'h7;
    end
  end

  beat_order u_order (
    .interleave_in (mode0_r[M0_BTYPE]),
    .is_write_in   (burst_write_r),
    .chop_in       (burst_chop_r),
    .start_in      (burst_start_r),
    .beat_in       (beat_r),
    .column_out    (col_nxt),
    .drive_out     (drive_nxt)
  );

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      burst_active_out <= 1'b0;
      column_out       <= 3'h0;
      dq_drive_en_out  <= 1'b0;
      dq_first_out     <= 1'b0;
    end else begin
      burst_active_out <= burst_r;
      column_out       <= col_nxt;
      dq_drive_en_out  <= burst_r && !burst_write_r && drive_nxt &&
                          !mode1_r[M1_QOFF];
      dq_first_out     <= burst_r && beat_r == 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  a_dll_reset_clears: assert property (@(posedge clk_in) disable iff (reset_in)
    mode_set_in && bank_in == BANK_MODE0 |=> !mode0_r[M0_DLLRST])
    else $error("dll reset bit not cleared");

  a_dll_reset_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
    mode_set_in && bank_in == BANK_MODE0 && addr_in[M0_DLLRST]
    |=> ##1 dll_reset_pulse_out)
    else $error("dll reset pulse missing");

  a_mode1_capture: assert property (@(posedge clk_in) disable iff (reset_in)
    mode_set_in && bank_in == BANK_MODE1 |=> ##1 mode1_out == $past(addr_in, 2))
    else $error("second register capture wrong");

  a_mode1_holds: assert property (@(posedge clk_in) disable iff (reset_in)
    !(mode_set_in && bank_in == BANK_MODE1) |=> $stable(mode1_r))
    else $error("second register changed");

  a_latency_off: assert property (@(posedge clk_in) disable iff (reset_in)
    mode1_r[M1_DLL_DIS] && $stable(mode1_r) |=> read_latency_out == LAT_DLL_OFF)
    else $error("dll off latency not six");

  a_chop_tristate: assert property (@(posedge clk_in) disable iff (reset_in)
    burst_r && burst_chop_r && beat_r[2] |=> !dq_drive_en_out)
    else $error("chopped burst drove late beats");

  a_write_order: assert property (@(posedge clk_in) disable iff (reset_in)
    burst_r && burst_write_r && !burst_chop_r |=> column_out == $past(beat_r))
    else $error("write order not linear");

  a_ppd_exit: assert property (@(posedge clk_in) disable iff (reset_in)
    !mode0_r[M0_PPD] && $stable(mode0_r) |=> pd_exit_delay_out == EXIT_SLOW)
    else $error("slow exit not applied");

  a_sr_dll_off: assert property (@(posedge clk_in) disable iff (reset_in)
    self_refresh_entry_in |=> ##1 !dll_running_out)
    else $error("dll runs in self refresh");

endmodule // sdram_mode_register_decode

/* File: tb_top.sv */
// Self-checking bench for the mode-register decode block.
// Assumes the controller model drives every command input.
module tb_top import mode_decode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int LOCK = 8;
  logic clk_in, reset_in, ms, rd, wr, ta, tn, run, rstp, lck, act, dqe, dqf;
  logic [3:0] pwr, rl, wrc, pdx;
  logic [2:0] bank, col;
  logic [16:0] addr, v, m1_o;
  logic [12:0] m0_o;
  logic [1:0] ds;
  logic [3:0] wr_tab [1:6] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc};
  logic [1:0] blc [0:2] = '{BL_CHOP4, BL_OTF, BL_FIXED8};
  int mismatches, comparisons;

  sdram_mode_register_decode #(.LOCK_CYC(LOCK)) DUT (
    .clk_in(clk_in), .reset_in(reset_in), .mode_set_in(ms), .read_in(rd),
    .write_in(wr), .self_refresh_entry_in(pwr[0]), .self_refresh_exit_in(pwr[1]),
    .power_down_entry_in(pwr[2]), .power_down_exit_in(pwr[3]), .bank_in(bank),
    .addr_in(addr), .mode0_out(m0_o), .mode1_out(m1_o), .read_latency_out(rl),
    .write_recovery_out(wrc), .drive_strength_out(ds), .term_all_allowed_out(ta),
    .term_allowed_out(tn), .dll_running_out(run), .dll_reset_pulse_out(rstp),
    .dll_locked_out(lck), .pd_exit_delay_out(pdx), .burst_active_out(act),
    .column_out(col), .dq_drive_en_out(dqe), .dq_first_out(dqf));

  ctl_model ctl (.clk_in(clk_in), .locked_in(lck), .mode_set_out(ms), .read_out(rd),
    .write_out(wr), .pwr_out(pwr), .bank_out(bank), .addr_out(addr));

  initial clk_in = 1'b0;
  always #2 clk_in = ~clk_in;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [16:0] m0(input logic [1:0] bl, input logic bt,
    input logic [2:0] cl, input logic dr, input logic [2:0] wrr, input logic ppd);
    return {4'h0, ppd, wrr, dr, 1'b0, cl, bt, 1'b0, bl};
  endfunction

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic settle;
    repeat (4) @(negedge clk_in);
  endtask

  task automatic wait_pulse;
    int k;
    k = 0;
    while (!rstp && k < 4) begin
      @(negedge clk_in);
      k++;
    end
    check(rstp, 1'b1);
  endtask

  // One burst; lat is the expected count of edges to the first beat
  task automatic burst(input logic w, input logic bt, input logic chop,
    input logic [2:0] s, input int lat);
    int k;
    logic [2:0] e;
    logic [2:0] b;
    ctl.cmd(w ? 2 : 1, 3'h0, {4'h0, !chop, 9'h0, s});
    k = 0;
    while (!act && k < 20) begin
      @(negedge clk_in);
      k++;
    end
    check(17'(k), 17'(lat));
    for (int i = 0; i < 8; i++) begin
      b = i[2:0];
      if (w) begin
        e = chop ? {s[2], b[1:0]} : b;
      end else if (bt) begin
        e = s ^ b;
      end else begin
        e = {s[2] ^ b[2], s[1:0] + b[1:0]};
      end
      if (!w) begin
        check(dqe, !(chop && b[2]));
        check(dqf, i == 0);
      end
      if (!(chop && b[2])) begin
        check(col, e);
      end
      @(negedge clk_in);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(negedge clk_in);
    mismatches++;
    wrap_up();
  end

  initial begin
    mismatches = 0;
    comparisons = 0;
    reset_in = 1'b1;
    repeat (5) @(negedge clk_in);
    reset_in = 1'b0;
    check(m1_o, 17'h0_0000);
    check(rl, 17'h0_0005);
    check(pdx, 17'h0_000a);
    ctl.mset(3'h1, 17'h0_0002);
    ctl.mset(3'h0, m0(BL_FIXED8, 1'b0, 3'h1, 1'b1, 3'h1, 1'b0));
    wait_pulse();
    settle();
    check(m0_o[8], 1'b0);
    check(ds, DS_RZQ7);
    check(tn, 1'b1);
    ctl.lock_wait(LOCK + 8);
    check(lck, 1'b1);
    for (int i = 1; i <= 6; i++) begin
      v = m0(BL_FIXED8, i[0], i[2:0], 1'b0, i[2:0], i[0]);
      ctl.mset(3'h0, v);
      settle();
      check(m0_o, v[12:0]);
      check(rl, 17'(i + 4));
      check(wrc, wr_tab[i]);
      check(pdx, i[0] ? 17'h0_0003 : 17'h0_000a);
      for (int s = 0; s < 8; s++) begin
        burst(1'b0, i[0], 1'b0, s[2:0], i + 4);
      end
    end
    for (int j = 0; j < 6; j++) begin
      ctl.mset(3'h0, m0(blc[j / 2], j[0], 3'h2, 1'b0, 3'h1, 1'b1));
      settle();
      for (int s = 0; s < 8; s++) begin
        for (int c = 0; c < 2; c++) begin
          if (j / 2 == 1 || c[0] == (j / 2 == 0)) begin
            burst(1'b0, j[0], c[0], s[2:0], 6);
            burst(1'b1, j[0], c[0], s[2:0], 2);
          end
        end
      end
    end
    for (int d = 0; d < 4; d++) begin
      v = (d[1] ? 17'h0_1020 : 17'h0_0000) | (d[0] ? 17'h0_c082 : 17'h0_0000);
      ctl.mset(3'h1, v);
      settle();
      check(m1_o, v);
      check(ds, 17'(d[1:0]));
      check(ta, d[0] & d[1]);
    end
    // A mode set to an unused bank must leave both registers alone
    ctl.mset(3'h6, 17'h1_ffff);
    settle();
    check(m1_o, v);
    check(m0_o, m0(BL_FIXED8, 1'b1, 3'h2, 1'b0, 3'h1, 1'b1));
    // A 30 ns recovery at a 4 ns clock rounds up to 8 cycles
    ctl.mset(3'h0, m0(BL_FIXED8, 1'b0, 3'h1, 1'b0, 3'((30 + 3) / 4 - 4), 1'b0));
    settle();
    check(wrc, 17'h0_0008);
    ctl.mset(3'h1, 17'h0_0002);
    for (int p = 0; p < 2; p++) begin
      ctl.mset(3'h0, m0(BL_FIXED8, 1'b0, 3'h1, 1'b0, 3'h1, p[0]));
      settle();
      ctl.pwr(2);
      settle();
      check(run, p[0]);
      ctl.pwr(3);
      settle();
      check(run, 1'b1);
    end
    ctl.pwr(0);
    settle();
    check(run, 1'b0);
    ctl.pwr(1);
    wait_pulse();
    settle();
    check(run, 1'b1);
    ctl.mset(3'h1, 17'h0_0003);
    settle();
    check(rl, LAT_DLL_OFF);
    check(tn, 1'b0);
    ctl.pwr(0);
    ctl.pwr(1);
    settle();
    check(run, 1'b0);
    check(m1_o, 17'h0_0003);
    wrap_up();
  end
endmodule // tb_top
